// *** test/rls_motor_model.sv ***
// behavioural motor-drive unit: counts tap steps and times the lower pulses
`timescale 1ns/1ns
`default_nettype none
module rls_motor_model (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic raise_in,
    input  wire logic lower_in,
    output int        raises,
    output int        lowers,
    output int        width,
    output int        period
);
    logic raise_q;
    logic lower_q;
    int   run;
    int   since;
    // a step starts on a rising command; the high time is the pulse length
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            {raise_q, lower_q} <= 2'b00;
            {raises, lowers, width, period, run, since} <= '0;
        end
        else
        begin
            raise_q <= raise_in;
            lower_q <= lower_in;
            since   <= since + 1;
            if (raise_in && !raise_q)
                raises <= raises + 1;
            if (lower_in && !lower_q)
            begin
                lowers <= lowers + 1;
                period <= since;
                since  <= 1;
            end
            if (lower_in)
                run <= lower_q ? run + 1 : 1;
            else if (lower_q)
                width <= run;
        end
    end
endmodule
`default_nettype wire

// *** test/rls_top_test.sv ***
// self-checking bench for the limit supervisor
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module rls_top_test;
    import rls_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, meas_valid;
    logic        ct_present, raise_req, lower_req, raise_out, lower_out, inhibit, uv_relay, sig_relay;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd_cap;
    rls_meas_s   meas;
    rls_lamp_s   lamp;
    int          failures, check_count, lowers, width, period;

    // short tick keeps the 60 s spacing at 6000 cycles
    rls_top #(.TICK_CYC(10)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .meas_valid(meas_valid), .meas(meas),
        .ct_present(ct_present), .raise_req(raise_req), .lower_req(lower_req), .raise_out(raise_out),
        .lower_out(lower_out), .inhibit(inhibit), .lamp(lamp), .uv_relay(uv_relay), .sig_relay(sig_relay));

    rls_motor_model motor_u (.hclk(hclk), .hresetn(hresetn), .raise_in(raise_out), .lower_in(lower_out),
        .raises(), .lowers(lowers), .width(width), .period(period));

    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic summarize;
        if (failures == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // looks ahead at the falling edge; inputs only move after rising edges
    task automatic wait_rdy;
        int n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && n < 64)
        begin
            n++;
            @(negedge hclk);
        end
        if (n == 64)
        begin
            failures++;
            summarize;
        end
        rd_cap = hrdata;
        @(posedge hclk);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        wait_rdy;
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        bus(1'b0, a, 32'h00000000);
        `CHK(nm, exp, rd_cap)
        `CHK({nm, "_resp"}, 1'b0, hresp)
    endtask

    // setpoint fixed at 100.0 V
    task automatic upd(input logic [15:0] v, input logic [7:0] c, input logic p);
        @(posedge hclk);
        meas       <= rls_meas_s'({v, 16'h03E8, c, p});
        meas_valid <= 1'b1;
        @(posedge hclk);
        meas_valid <= 1'b0;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
    endtask

    task automatic outs(input logic [7:0] exp, input string nm);
        `CHK(nm, exp, {lamp, uv_relay, sig_relay, inhibit, raise_out})
    endtask

    initial
    begin
        int n;
        {hresetn, hsel, hwrite, meas_valid, ct_present, raise_req, lower_req} = '0;
        {htrans, haddr, hwdata} = '0;
        meas = '0;
        {failures, check_count} = '0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(8'h00, 32'h00000000, "ctrl");
        rchk(8'h04, 32'h00006E6E, "vlim");
        rchk(8'h08, 32'h0000006E, "ilim");
        rchk(8'h0C, 32'h00000064, "uvdly");
        rchk(8'h10, 32'h0000000F, "pulse");
        rchk(8'h18, 32'h00000000, "unmapped");
        bus(1'b1, 8'h04, 32'h0000965A);
        rchk(8'h04, 32'h00008C64, "vlim_clamp");
        bus(1'b1, 8'h08, 32'h0000FF14);
        rchk(8'h08, 32'h0000D232, "ilim_clamp");
        bus(1'b1, 8'h04, 32'h00007864);
        bus(1'b1, 8'h08, 32'h0000326E);
        bus(1'b1, 8'h0C, 32'h00000002);
        bus(1'b1, 8'h10, 32'h00000002);
        raise_req <= 1'b1;
        upd(16'h044C, 8'h6E, 1'b0);
        outs(8'h01, "oc_edge");
        upd(16'h044C, 8'h78, 1'b0);
        outs(8'h45, "oc_sig");
        bus(1'b1, 8'h00, 32'h00000008);
        upd(16'h044C, 8'h78, 1'b0);
        outs(8'h46, "oc_blk");
        bus(1'b1, 8'h00, 32'h00000000);
        upd(16'h044C, 8'h28, 1'b0);
        outs(8'h85, "uc_sig");
        bus(1'b1, 8'h00, 32'h00000010);
        upd(16'h044C, 8'h28, 1'b0);
        outs(8'h86, "uc_blk");
        bus(1'b1, 8'h00, 32'h00000020);
        upd(16'h044C, 8'h64, 1'b1);
        outs(8'h01, "np_no_ct");
        ct_present <= 1'b1;
        bus(1'b1, 8'h00, 32'h00000060);
        upd(16'h044C, 8'h64, 1'b1);
        outs(8'h02, "np_blk");
        bus(1'b1, 8'h00, 32'h00000040);
        upd(16'h044C, 8'h64, 1'b1);
        outs(8'h01, "np_off");
        bus(1'b1, 8'h00, 32'h00000000);
        upd(16'h0384, 8'h64, 1'b0);
        outs(8'h11, "uv_early");
        repeat (40) @(posedge hclk);
        outs(8'h19, "uv_late");
        bus(1'b1, 8'h00, 32'h00000001);
        upd(16'h0384, 8'h64, 1'b0);
        outs(8'h1A, "uv_blk");
        bus(1'b1, 8'h00, 32'h00000002);
        upd(16'h00C8, 8'h64, 1'b0);
        repeat (40) @(posedge hclk);
        outs(8'h01, "uv_off_sup");
        bus(1'b1, 8'h00, 32'h00000000);
        upd(16'h00C8, 8'h64, 1'b0);
        outs(8'h11, "uv_off_nosup");
        // blocked overvoltage: no pulses even with a lower request standing
        bus(1'b1, 8'h00, 32'h00000004);
        upd(16'h0514, 8'h64, 1'b0);
        @(posedge hclk);
        lower_req <= 1'b1;
        repeat (100) @(posedge hclk);
        outs(8'h26, "ov_blk");
        `CHK("ov_blk_taps", 0, lowers)
        rchk(8'h14, 32'h000000A4, "stat_ov_blk");
        lower_req <= 1'b0;
        bus(1'b1, 8'h00, 32'h00000000);
        upd(16'h0514, 8'h64, 1'b0);
        for (n = 0; n < 13000 && lowers < 2; n++)
            @(posedge hclk);
        if (lowers < 2)
        begin
            failures++;
            summarize;
        end
        `CHK("rapid_raise", 1'b0, raise_out)
        `CHK("rapid_lamp", 1'b1, lamp.ov)
        `CHK("pulse_len", 20, width)
        `CHK("pulse_gap", 6000, period)
        upd(16'h044C, 8'h64, 1'b0);
        `CHK("ov_clear", 5'b00000, {lamp, sig_relay})
        repeat (7000) @(posedge hclk);
        `CHK("ov_stop", 2, lowers)
        `CHK("raise_back", 1'b1, raise_out)
        summarize;
    end
endmodule
`default_nettype wire

// *** verilog/rls_pkg.sv ***
// types shared by the limit supervisor
package rls_pkg;
    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] vset;
        logic [7:0]  cur;
        logic        pneg;
    } rls_meas_s;
    typedef struct packed {
        logic np_blk;
        logic uc_blk;
        logic oc_blk;
        logic ov_blk;
        logic sup30;
        logic uv_blk;
    } rls_cfg_s;
    typedef struct packed {
        logic uc;
        logic oc;
        logic ov;
        logic uv;
    } rls_lamp_s;
    typedef enum logic [1:0] {RL_IDLE, RL_PULSE, RL_GAP} rls_rl_e;
endpackage

// *** verilog/rls_regs.svh ***
// register map, reset values and timing counts of the limit supervisor
`ifndef RLS_REGS_SVH
`define RLS_REGS_SVH
`define RLS_OFF_CTRL   8'h00
`define RLS_OFF_VLIM   8'h04
`define RLS_OFF_ILIM   8'h08
`define RLS_OFF_UVDLY  8'h0C
`define RLS_OFF_PULSE  8'h10
`define RLS_OFF_STAT   8'h14
`define RLS_CTRL_RST   7'h00
`define RLS_UV_RST     8'h6E
`define RLS_OV_RST     8'h6E
`define RLS_OC_RST     8'h6E
`define RLS_UC_RST     8'h00
`define RLS_UVDLY_RST  8'h64
`define RLS_PULSE_RST  8'h0F
`define RLS_V_LO       8'h64
`define RLS_V_HI       8'h8C
`define RLS_OC_LO      8'h32
`define RLS_I_HI       8'hD2
`define RLS_UVDLY_HI   8'hC8
`define RLS_PULSE_LO   8'h01
`define RLS_PULSE_HI   8'h64
`define RLS_OFF_VOLT   16'h012C
`define RLS_CLK_NS     4
`define RLS_TICK_NS    100000000
`define RLS_GAP_S      60
`define RLS_GAP_TICKS  (`RLS_GAP_S * 10)
`endif

// *** verilog/rls_top.sv ***
// limit supervisor with ahb-lite registers and rapid return lowering
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "rls_regs.svh"
module rls_top
    import rls_pkg::*;
#(
    parameter int unsigned TICK_CYC = `RLS_TICK_NS / `RLS_CLK_NS
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        meas_valid,
    input  wire rls_meas_s   meas,
    input  wire logic        ct_present,
    input  wire logic        raise_req,
    input  wire logic        lower_req,
    output logic             raise_out,
    output logic             lower_out,
    output logic             inhibit,
    output rls_lamp_s        lamp,
    output logic             uv_relay,
    output logic             sig_relay
);
    rls_cfg_s    cfg_reg;
    logic        ct_cfg_reg;
    logic [7:0]  uv_pct_reg, ov_pct_reg, oc_pct_reg, uc_pct_reg;
    logic [7:0]  uvdly_reg, pulse_reg;
    logic        wr_pend_reg, rd_pend_reg;
    logic [7:0]  addr_reg;
    logic        ov_reg, uv_reg, off_reg, oc_reg, uc_reg, pneg_reg;
    logic [24:0] tick_cnt;
    logic        tick, tick_clr;
    logic [7:0]  uv_cnt;
    rls_rl_e     rl_state;
    logic [9:0]  rl_cnt;
    logic        uv_ind, rapid, inhibit_next, ct_ok;
    logic        rl_start, gap_end;
    logic [31:0] rd_mux;

    // clamp keeps settings inside their legal range
    function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        if (v < lo)
            return lo;
        else if (v > hi)
            return hi;
        return v;
    endfunction

    // one extra cycle on reads so read-after-write returns new data
    assign hreadyout = !rd_pend_reg;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            rd_pend_reg <= hsel && htrans[1] && !hwrite;
            addr_reg    <= haddr[7:0];
        end
        else
            rd_pend_reg <= 1'b0;
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (addr_reg)
            `RLS_OFF_CTRL:  rd_mux = {25'h0, ct_cfg_reg, cfg_reg};
            `RLS_OFF_VLIM:  rd_mux = {16'h0, ov_pct_reg, uv_pct_reg};
            `RLS_OFF_ILIM:  rd_mux = {16'h0, uc_pct_reg, oc_pct_reg};
            `RLS_OFF_UVDLY: rd_mux = {24'h0, uvdly_reg};
            `RLS_OFF_PULSE: rd_mux = {24'h0, pulse_reg};
            `RLS_OFF_STAT:  rd_mux = {22'h0, ct_ok, rapid, sig_relay, uv_relay, inhibit, lamp, lower_out};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (rd_pend_reg)
            hrdata <= rd_mux;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // ct_cfg sits above the six enables in the control word
            {ct_cfg_reg, cfg_reg} <= `RLS_CTRL_RST;
            uv_pct_reg <= `RLS_UV_RST;
            ov_pct_reg <= `RLS_OV_RST;
            oc_pct_reg <= `RLS_OC_RST;
            uc_pct_reg <= `RLS_UC_RST;
            uvdly_reg  <= `RLS_UVDLY_RST;
            pulse_reg  <= `RLS_PULSE_RST;
        end
        else if (wr_pend_reg)
        begin
            case (addr_reg)
                `RLS_OFF_CTRL:
                begin
                    cfg_reg    <= hwdata[5:0];
                    ct_cfg_reg <= hwdata[6];
                end
                `RLS_OFF_VLIM:
                begin
                    uv_pct_reg <= clamp(hwdata[7:0], `RLS_V_LO, `RLS_V_HI);
                    ov_pct_reg <= clamp(hwdata[15:8], `RLS_V_LO, `RLS_V_HI);
                end
                `RLS_OFF_ILIM:
                begin
                    oc_pct_reg <= clamp(hwdata[7:0], `RLS_OC_LO, `RLS_I_HI);
                    uc_pct_reg <= clamp(hwdata[15:8], 8'h00, `RLS_I_HI);
                end
                `RLS_OFF_UVDLY: uvdly_reg <= clamp(hwdata[7:0], 8'h00, `RLS_UVDLY_HI);
                `RLS_OFF_PULSE: pulse_reg <= clamp(hwdata[7:0], `RLS_PULSE_LO, `RLS_PULSE_HI);
                default: ;
            endcase
        end
    end

    // voltage limits compared in 0.1 V units scaled by 100 to avoid division; current limits compared directly
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ov_reg   <= 1'b0;
            uv_reg   <= 1'b0;
            off_reg  <= 1'b0;
            oc_reg   <= 1'b0;
            uc_reg   <= 1'b0;
            pneg_reg <= 1'b0;
        end
        else if (meas_valid)
        begin
            ov_reg   <= 24'(meas.volt) * 24'h64 > 24'(meas.vset) * 24'(ov_pct_reg);
            uv_reg   <= 24'(meas.volt) * 24'h64 < 24'(meas.vset) * 24'(uv_pct_reg);
            off_reg  <= meas.volt < `RLS_OFF_VOLT;
            oc_reg   <= meas.cur > oc_pct_reg;
            uc_reg   <= meas.cur < uc_pct_reg;
            pneg_reg <= meas.pneg;
        end
    end

    // 0.1 s timebase, restarted at a rapid pulse so its length is exact
    assign tick = tick_cnt == 25'(TICK_CYC - 1);
    // a new pulse follows straight from the gap so spacing is exactly 60 s
    assign gap_end = rl_state == RL_GAP && tick && rl_cnt + 10'h1 >= 10'(`RLS_GAP_TICKS);
    assign rl_start = rapid && (rl_state == RL_IDLE || gap_end);
    assign tick_clr = rl_start;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tick_cnt <= 25'h0;
        else if (tick || tick_clr)
            tick_cnt <= 25'h0;
        else
            tick_cnt <= tick_cnt + 25'h1;
    end

    assign uv_ind = uv_reg && !(cfg_reg.sup30 && off_reg);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            uv_cnt <= 8'h00;
        else if (!uv_ind)
            uv_cnt <= 8'h00;
        else if (tick && uv_cnt < uvdly_reg)
            uv_cnt <= uv_cnt + 8'h01;
    end

    // rapid return ignores the switching_delay_timer by design
    assign rapid = ov_reg && !cfg_reg.ov_blk;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rl_state <= RL_IDLE;
            rl_cnt   <= 10'h0;
        end
        else
        begin
            case (rl_state)
                RL_IDLE:
                    if (rapid)
                    begin
                        rl_state <= RL_PULSE;
                        rl_cnt   <= 10'h0;
                    end
                RL_PULSE:
                    if (tick)
                    begin
                        rl_cnt <= rl_cnt + 10'h1;
                        if (rl_cnt + 10'h1 >= 10'(pulse_reg))
                            rl_state <= RL_GAP;
                    end
                // overvoltage still present at gap end chains the next pulse
                RL_GAP:
                    if (rl_start)
                    begin
                        rl_state <= RL_PULSE;
                        rl_cnt   <= 10'h0;
                    end
                    else if (gap_end)
                        rl_state <= RL_IDLE;
                    else if (tick)
                        rl_cnt <= rl_cnt + 10'h1;
                default: rl_state <= RL_IDLE;
            endcase
        end
    end

    assign ct_ok = ct_present && ct_cfg_reg;
    assign inhibit_next = (uv_reg && cfg_reg.uv_blk)
        || (ov_reg && cfg_reg.ov_blk)
        || (oc_reg && cfg_reg.oc_blk)
        || (uc_reg && cfg_reg.uc_blk)
        || (pneg_reg && cfg_reg.np_blk && ct_ok);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            inhibit   <= 1'b0;
            raise_out <= 1'b0;
            lower_out <= 1'b0;
            lamp      <= '0;
            uv_relay  <= 1'b0;
            sig_relay <= 1'b0;
        end
        else
        begin
            inhibit   <= inhibit_next;
            raise_out <= raise_req && !inhibit_next && !rapid && rl_state == RL_IDLE;
            lower_out <= (rl_state == RL_PULSE)
                || (lower_req && !inhibit_next && !rapid && rl_state == RL_IDLE);
            lamp.uv   <= uv_ind;
            lamp.ov   <= ov_reg;
            lamp.oc   <= oc_reg;
            lamp.uc   <= uc_reg;
            uv_relay  <= uv_ind && uv_cnt >= uvdly_reg;
            sig_relay <= ov_reg || oc_reg || uc_reg;
        end
    end

    // helper counters for the checks below
    // 60 s at the real tick rate overflows 32 bits, hence the wider gap counter
    logic [39:0] since_pulse;
    logic [31:0] pulse_len;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            since_pulse <= 40'hFF_FFFF_FFFF;
            pulse_len   <= 32'h0;
        end
        else
        begin
            if (tick_clr)
                since_pulse <= 40'h00_0000_0000;
            else if (since_pulse != 40'hFF_FFFF_FFFF)
                since_pulse <= since_pulse + 40'h01;
            pulse_len <= (rl_state == RL_PULSE) ? pulse_len + 32'h1 : 32'h0;
        end
    end

    sequence rl_enter_s;
        rl_state == RL_IDLE && rapid;
    endsequence
    sequence rl_drive_s;
        rl_state == RL_PULSE ##1 lower_out;
    endsequence

    rl_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rl_enter_s |=> rl_drive_s) else $error("rapid pulse not started");
    // since_pulse lags the interval by one cycle at the next start
    rl_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        tick_clr && since_pulse != 40'hFF_FFFF_FFFF
        |-> since_pulse >= 40'(`RLS_GAP_TICKS) * 40'(TICK_CYC) - 40'h01)
        else $error("rapid pulses too close");
    rl_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(rl_state == RL_PULSE) |-> pulse_len == 32'(pulse_reg) * TICK_CYC)
        else $error("rapid pulse length wrong");
    ov_lamp_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ov_reg |=> lamp.ov && sig_relay) else $error("overvoltage signal missing");
    ov_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ov_reg && cfg_reg.ov_blk |=> inhibit && !raise_out && rl_state == RL_IDLE)
        else $error("overvoltage not blocking");
    uv_sup_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg_reg.sup30 && off_reg |=> !lamp.uv && !uv_relay) else $error("uv signal not suppressed");
    uv_blk_a: assert property (@(posedge hclk) disable iff (!hresetn)
        uv_reg && cfg_reg.uv_blk |=> inhibit && !raise_out) else $error("undervoltage not blocking");
    oc_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
        oc_reg && !cfg_reg.oc_blk && !uv_reg && !ov_reg && !uc_reg && !pneg_reg |=> !inhibit && lamp.oc)
        else $error("overcurrent handling wrong");
    uc_blk_a: assert property (@(posedge hclk) disable iff (!hresetn)
        uc_reg && cfg_reg.uc_blk |=> inhibit) else $error("undercurrent not blocking");
    np_ct_a: assert property (@(posedge hclk) disable iff (!hresetn)
        inhibit && $past(pneg_reg && cfg_reg.np_blk) && !$past(inhibit_next && !(pneg_reg && cfg_reg.np_blk))
        |-> $past(ct_ok)) else $error("negative power block without ct");
endmodule
`default_nettype wire
